// >>> src/sbr_pkg.sv
/*
 * Shared constants, command codes and carrier structs for the status byte
 * and standard event reporting block.
 * Assumes a command parser on the same clock that decodes the controller's
 * text commands into the command codes below.
 */
package sbr_pkg;

    localparam int REG_W   = 8;
    localparam int ERR_W   = 16;
    localparam int ERRQ_DEPTH = 8;

    // Status byte bit positions
    localparam int SB_ERRQ_BIT = 2;
    localparam int SB_MAV_BIT  = 4;
    localparam int SB_ESUM_BIT = 5;
    localparam int SB_MSS_BIT  = 6;

    // Standard event bit positions
    localparam int EV_OPC_BIT  = 0;
    localparam int EV_QRY_BIT  = 2;
    localparam int EV_DEV_BIT  = 3;
    localparam int EV_EXE_BIT  = 4;
    localparam int EV_CMD_BIT  = 5;
    localparam int EV_USR_BIT  = 6;
    localparam int EV_PON_BIT  = 7;

    // Reset values: the power-on event is already latched when reset releases
    localparam logic [7:0] EV_RESET       = 8'h80;
    localparam logic [7:0] EV_MASK_RESET  = 8'h00;
    localparam logic [7:0] SRQ_MASK_RESET = 8'h00;
    // Writable bits of the service request mask; bit 6 always reads zero
    localparam logic [7:0] SRQ_MASK_WR    = 8'hBF;

    // Error number ranges and substitutes for out-of-range numbers
    localparam logic signed [15:0] DEV_ERR_HI  = -16'sd300;
    localparam logic signed [15:0] DEV_ERR_LO  = -16'sd399;
    localparam logic signed [15:0] EXE_ERR_HI  = -16'sd200;
    localparam logic signed [15:0] EXE_ERR_LO  = -16'sd300;
    localparam logic signed [15:0] CMD_ERR_HI  = -16'sd100;
    localparam logic signed [15:0] CMD_ERR_LO  = -16'sd200;
    localparam logic [15:0]        NO_ERROR    = 16'h0000;

    typedef enum logic [3:0] {
        CMD_NONE          = 4'h0,
        CMD_SB_QUERY      = 4'h1,
        CMD_EV_QUERY      = 4'h2,
        CMD_EVMASK_SET    = 4'h3,
        CMD_EVMASK_QUERY  = 4'h4,
        CMD_SRQMASK_SET   = 4'h5,
        CMD_SRQMASK_QUERY = 4'h6,
        CMD_OPC           = 4'h7,
        CMD_ERR_QUERY     = 4'h8,
        CMD_CLEAR         = 4'h9
    } sbr_cmd_t;

    typedef struct packed {
        logic       valid;
        sbr_cmd_t   code;
        logic [7:0] data;
    } sbr_cmd_req_t;

    typedef struct packed {
        logic               valid;
        logic signed [15:0] code;
    } sbr_err_evt_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } sbr_rsp_t;

endpackage

// >>> src/sbr_pin_sync.sv
/*
 * Three-stage synchroniser for a level arriving from outside the clock domain.
 * The output follows only once the second and third stages agree.
 */
`timescale 1ns/1ns
module sbr_pin_sync (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    input  wire logic pin_i,
    output logic      level_o
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_level;

    always_comb begin
        next_stage = {stage[1:0], pin_i};
        next_level = level_o;
        if (stage[2] == stage[1]) begin
            next_level = stage[2];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stage   <= 3'h0;
            level_o <= 1'b0;
        end else if (ce_i) begin
            stage   <= next_stage;
            level_o <= next_level;
        end
    end
endmodule

// >>> src/sbr_err_queue.sv
/*
 * Error queue: a small FIFO of error numbers whose head is always held in a
 * register. Assumes push and pop are single-cycle strobes on the same clock.
 */
`timescale 1ns/1ns
module sbr_err_queue #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             ce_i,
    input  wire logic             clr_i,
    input  wire logic             push_i,
    input  wire logic [WIDTH-1:0] push_data_i,
    input  wire logic             pop_i,
    output logic      [WIDTH-1:0] head_o,
    output logic                  empty_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    rd_ptr;
    logic [PW-1:0]    wr_ptr;
    logic [CW-1:0]    count;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW-1:0]    next_wr_ptr;
    logic [CW-1:0]    next_count;
    logic [WIDTH-1:0] next_head;
    logic             do_push;
    logic             do_pop;

    function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
        inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    always_comb begin
        do_pop      = pop_i && (count != '0);
        // A full queue drops new entries unless one leaves or a clear comes in the same cycle
        do_push     = push_i && ((count != CW'(DEPTH)) || do_pop || clr_i);
        next_rd_ptr = do_pop ? inc(rd_ptr) : rd_ptr;
        next_wr_ptr = do_push ? inc(wr_ptr) : wr_ptr;
        next_count  = count + CW'(do_push) - CW'(do_pop);
        next_head   = head_o;
        if (do_pop) begin
            if (count > CW'(1)) begin
                next_head = mem[inc(rd_ptr)];
            end else if (do_push) begin
                next_head = push_data_i;
            end else begin
                next_head = '0;
            end
        end else if (do_push && count == '0) begin
            next_head = push_data_i;
        end
        if (clr_i) begin
            // A push in the clearing cycle survives so a fresh fault is not lost
            next_rd_ptr = wr_ptr;
            next_wr_ptr = do_push ? inc(wr_ptr) : wr_ptr;
            next_count  = do_push ? CW'(1) : '0;
            next_head   = do_push ? push_data_i : '0;
        end
    end

    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    mem[i] <= '0;
                end else if (ce_i && do_push && wr_ptr == PW'(i)) begin
                    mem[i] <= push_data_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count  <= '0;
            head_o <= '0;
        end else if (ce_i) begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count  <= next_count;
            head_o <= next_head;
        end
    end

    assign empty_o = (count == '0);
endmodule

// >>> src/sbr_status_top.sv
/*
 * Status byte, standard event register, their enable masks and the error
 * queue behind them, driven by decoded controller commands.
 * Assumes a command parser on CORE_CLK_I delivering one-cycle command and
 * error strobes, and an output buffer that reports its own message level.
 * The local-control key arrives asynchronously on a pin.
 */
`timescale 1ns/1ns
// Function
// - Status byte query returns byte unchanged
// - Queued error sets bit 2, requests service
// - Bit 4 while response message readable
// - Bit 5 is OR of enabled events
// - Bit 6 when enabled status bit set
// - Operation complete sets event bit 0
// - Bad read or unread response: bit 2
// - Device fault: bit 3, queue -300..-399 or positive
// - Execution fault: bit 4, queue -200..-300
// - Command fault: bit 5, queue -100..-200
// - Local key sets event bit 6
// - Power-up sets event bit 7
// - Event query; event mask write and read
// - Reading event register clears it
// - Service mask bit 6 always zero
module sbr_status_top
    import sbr_pkg::*;
#(
    parameter int ERRQ_DEPTH_P = sbr_pkg::ERRQ_DEPTH
) (
    input  wire logic                  CORE_CLK_I,
    input  wire logic                  NRST_I,
    input  wire logic                  CE_I,
    input  wire sbr_pkg::sbr_cmd_req_t CMD_I,
    input  wire logic                  RD_REQ_I,
    input  wire logic                  MAV_I,
    input  wire logic                  ALL_DONE_I,
    input  wire sbr_pkg::sbr_err_evt_t DEV_ERR_I,
    input  wire sbr_pkg::sbr_err_evt_t EXE_ERR_I,
    input  wire sbr_pkg::sbr_err_evt_t CMD_ERR_I,
    input  wire logic                  LOCAL_KEY_I,
    output sbr_pkg::sbr_rsp_t          RSP_O,
    output logic [7:0]                 STATUS_BYTE_O,
    output logic                       SRQ_O
);
    import sbr_pkg::*;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_HOLD = 1'b1
    } sbr_state_t;

    sbr_state_t        state;
    sbr_state_t        next_state;
    sbr_rsp_t          next_rsp;

    logic [7:0]        ev_status;
    logic [7:0]        ev_mask;
    logic [7:0]        srq_mask;
    logic              opc_armed;
    logic              key_prev;
    logic [7:0]        next_ev_status;
    logic [7:0]        next_ev_mask;
    logic [7:0]        next_srq_mask;
    logic              next_opc_armed;
    logic [7:0]        next_status_byte;
    logic              next_srq;

    logic              key_level;
    logic [7:0]        sb_now;
    logic [7:0]        ev_set;
    logic              cmd_take;
    logic              qry_err;
    logic              user_req;

    logic [ERR_W-1:0]  errq_head;
    logic              errq_empty;
    logic              errq_push;
    logic [ERR_W-1:0]  errq_data;
    logic              errq_pop;
    logic              errq_clr;

    // Keep an error number inside its class range; out-of-range numbers fall
    // back to the top of the range; the execution and device tops -200 and -300 also lie in the range above.
    function automatic logic [15:0] fix_code(
        input logic signed [15:0] code,
        input logic signed [15:0] hi,
        input logic signed [15:0] lo,
        input logic               allow_pos
    );
        if ((code <= hi && code >= lo) || (allow_pos && code > 16'sd0)) begin
            fix_code = code;
        end else begin
            fix_code = hi;
        end
    endfunction

    sbr_pin_sync u_key_sync (
        .clk_i   (CORE_CLK_I),
        .nrst_i  (NRST_I),
        .ce_i    (CE_I),
        .pin_i   (LOCAL_KEY_I),
        .level_o (key_level)
    );

    sbr_err_queue #(
        .WIDTH (ERR_W),
        .DEPTH (ERRQ_DEPTH_P)
    ) u_err_queue (
        .clk_i       (CORE_CLK_I),
        .nrst_i      (NRST_I),
        .ce_i        (CE_I),
        .clr_i       (errq_clr),
        .push_i      (errq_push),
        .push_data_i (errq_data),
        .pop_i       (errq_pop),
        .head_o      (errq_head),
        .empty_o     (errq_empty)
    );

    // Present status byte; undefined bits stay zero
    always_comb begin
        sb_now                = 8'h00;
        sb_now[SB_ERRQ_BIT]   = !errq_empty;
        sb_now[SB_MAV_BIT]    = MAV_I || (state == ST_HOLD);
        sb_now[SB_ESUM_BIT]   = |(ev_status & ev_mask);
        sb_now[SB_MSS_BIT]    = |(sb_now & srq_mask);
    end

    // Error queue feed: one entry per cycle, command errors first
    always_comb begin
        errq_push = 1'b0;
        errq_data = NO_ERROR;
        if (CMD_ERR_I.valid) begin
            errq_push = 1'b1;
            errq_data = fix_code(CMD_ERR_I.code, CMD_ERR_HI, CMD_ERR_LO, 1'b0);
        end else if (EXE_ERR_I.valid) begin
            errq_push = 1'b1;
            errq_data = fix_code(EXE_ERR_I.code, EXE_ERR_HI, EXE_ERR_LO, 1'b0);
        end else if (DEV_ERR_I.valid) begin
            errq_push = 1'b1;
            errq_data = fix_code(DEV_ERR_I.code, DEV_ERR_HI, DEV_ERR_LO, 1'b1);
        end
    end

    // Command handling and response holding
    always_comb begin
        cmd_take   = CMD_I.valid && CMD_I.code != CMD_NONE;
        next_state = state;
        next_rsp   = RSP_O;
        errq_pop   = 1'b0;
        errq_clr   = 1'b0;
        qry_err    = 1'b0;

        if (state == ST_HOLD && RD_REQ_I) begin
            next_state     = ST_IDLE;
            next_rsp.valid = 1'b0;
        end else if (state == ST_IDLE && RD_REQ_I && !MAV_I) begin
            qry_err = 1'b1;
        end

        if (cmd_take) begin
            // Unread answer abandoned by a new instruction
            if (state == ST_HOLD && !RD_REQ_I) begin
                qry_err        = 1'b1;
                next_state     = ST_IDLE;
                next_rsp.valid = 1'b0;
            end
            case (CMD_I.code)
                CMD_SB_QUERY: begin
                    next_rsp = '{valid: 1'b1, data: {8'h00, sb_now}};
                end
                CMD_EV_QUERY: begin
                    next_rsp = '{valid: 1'b1, data: {8'h00, ev_status}};
                end
                CMD_EVMASK_QUERY: begin
                    next_rsp = '{valid: 1'b1, data: {8'h00, ev_mask}};
                end
                CMD_SRQMASK_QUERY: begin
                    next_rsp = '{valid: 1'b1, data: {8'h00, srq_mask}};
                end
                CMD_ERR_QUERY: begin
                    next_rsp = '{valid: 1'b1, data: errq_empty ? NO_ERROR : errq_head};
                    errq_pop = 1'b1;
                end
                CMD_CLEAR: begin
                    errq_clr = 1'b1;
                end
                default: begin
                end
            endcase
            if (CMD_I.code == CMD_SB_QUERY || CMD_I.code == CMD_EV_QUERY ||
                CMD_I.code == CMD_EVMASK_QUERY || CMD_I.code == CMD_SRQMASK_QUERY ||
                CMD_I.code == CMD_ERR_QUERY) begin
                next_state = ST_HOLD;
            end
        end
    end

    // Event register, masks and operation-complete tracking
    always_comb begin
        user_req       = key_level && !key_prev;
        next_opc_armed = opc_armed;
        next_ev_mask   = ev_mask;
        next_srq_mask  = srq_mask;

        ev_set              = 8'h00;
        ev_set[EV_OPC_BIT]  = opc_armed && ALL_DONE_I;
        ev_set[EV_QRY_BIT]  = qry_err;
        ev_set[EV_DEV_BIT]  = DEV_ERR_I.valid;
        ev_set[EV_EXE_BIT]  = EXE_ERR_I.valid;
        ev_set[EV_CMD_BIT]  = CMD_ERR_I.valid;
        ev_set[EV_USR_BIT]  = user_req;

        if (opc_armed && ALL_DONE_I) begin
            next_opc_armed = 1'b0;
        end

        // A read or clear empties the register, but an event in that same
        // cycle still lands so nothing is lost between two reads.
        next_ev_status = ev_status;
        if (cmd_take && (CMD_I.code == CMD_EV_QUERY || CMD_I.code == CMD_CLEAR)) begin
            next_ev_status = 8'h00;
        end
        next_ev_status = next_ev_status | ev_set;

        if (cmd_take) begin
            case (CMD_I.code)
                CMD_OPC: begin
                    // Arm now; completion is judged from the next cycle on
                    next_opc_armed = 1'b1;
                end
                CMD_EVMASK_SET: begin
                    next_ev_mask = CMD_I.data;
                end
                CMD_SRQMASK_SET: begin
                    next_srq_mask = CMD_I.data & SRQ_MASK_WR;
                end
                CMD_CLEAR: begin
                    next_opc_armed = 1'b0;
                end
                default: begin
                end
            endcase
        end

        next_status_byte = sb_now;
        next_srq         = sb_now[SB_MSS_BIT];
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state     <= ST_IDLE;
            RSP_O     <= '0;
        end else if (CE_I) begin
            state     <= next_state;
            RSP_O     <= next_rsp;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ev_status     <= EV_RESET;
            ev_mask       <= EV_MASK_RESET;
            srq_mask      <= SRQ_MASK_RESET;
            opc_armed     <= 1'b0;
            key_prev      <= 1'b0;
            STATUS_BYTE_O <= 8'h00;
            SRQ_O         <= 1'b0;
        end else if (CE_I) begin
            ev_status     <= next_ev_status;
            ev_mask       <= next_ev_mask;
            srq_mask      <= next_srq_mask;
            opc_armed     <= next_opc_armed;
            key_prev      <= key_level;
            STATUS_BYTE_O <= next_status_byte;
            SRQ_O         <= next_srq;
        end
    end

endmodule

// >>> tb/sbr_status_chk.sv
/* Port-level assertions for the status byte and event reporting block.
   Assumes sbr_pkg is compiled first; bound into sbr_status_top below. */
`timescale 1ns/1ns
module sbr_status_chk
    import sbr_pkg::*;
#(
    parameter int ERRQ_DEPTH_P = 8
) (
    input wire logic                  CORE_CLK_I,
    input wire logic                  NRST_I,
    input wire logic                  CE_I,
    input wire sbr_pkg::sbr_cmd_req_t CMD_I,
    input wire logic                  RD_REQ_I,
    input wire logic                  MAV_I,
    input wire logic                  ALL_DONE_I,
    input wire sbr_pkg::sbr_err_evt_t DEV_ERR_I,
    input wire sbr_pkg::sbr_err_evt_t EXE_ERR_I,
    input wire sbr_pkg::sbr_err_evt_t CMD_ERR_I,
    input wire logic                  LOCAL_KEY_I,
    input wire sbr_pkg::sbr_rsp_t     RSP_O,
    input wire logic [7:0]            STATUS_BYTE_O,
    input wire logic                  SRQ_O
);
    // Clock enable low freezes everything, so attempts in flight are dropped
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!NRST_I || !CE_I);
    logic is_qry;
    assign is_qry = CMD_I.valid && (CMD_I.code inside {CMD_SB_QUERY, CMD_EV_QUERY, CMD_EVMASK_QUERY,
                                                       CMD_SRQMASK_QUERY, CMD_ERR_QUERY});
    a_srq_mss: assert property (SRQ_O == STATUS_BYTE_O[6])
        else $error("service request differs from summary bit");
    a_undef_zero: assert property ((STATUS_BYTE_O & 8'h8B) == 8'h00)
        else $error("undefined status bit set");
    a_mav_bit: assert property (MAV_I ##1 MAV_I |=> STATUS_BYTE_O[4])
        else $error("message bit missing");
    a_err_bit: assert property ((CMD_ERR_I.valid || EXE_ERR_I.valid || DEV_ERR_I.valid) && !CMD_I.valid
                                |-> ##2 STATUS_BYTE_O[2])
        else $error("queue bit missing after fault");
    a_query_ans: assert property (is_qry |=> RSP_O.valid)
        else $error("query not answered");
    a_sb_value: assert property (CMD_I.valid && CMD_I.code == CMD_SB_QUERY
                                 |=> RSP_O.data == {8'h00, STATUS_BYTE_O})
        else $error("status answer differs");
    a_srq_mask6: assert property (CMD_I.valid && CMD_I.code == CMD_SRQMASK_QUERY |=> !RSP_O.data[6])
        else $error("service mask bit 6 set");
    a_ev_undef: assert property (CMD_I.valid && CMD_I.code == CMD_EV_QUERY
                                 |=> RSP_O.data[15:8] == 8'h00 && !RSP_O.data[1])
        else $error("event answer undefined bits set");
    a_rsp_hold: assert property (RSP_O.valid && !RD_REQ_I && !CMD_I.valid
                                 |=> RSP_O.valid && $stable(RSP_O.data))
        else $error("unread answer lost");
    c_srq: cover property ($rose(SRQ_O));
    c_sbq: cover property (CMD_I.valid && CMD_I.code == CMD_SB_QUERY ##1 RSP_O.valid);
    c_read: cover property (RSP_O.valid && RD_REQ_I);
endmodule

bind sbr_status_top sbr_status_chk #(.ERRQ_DEPTH_P(ERRQ_DEPTH_P)) u_sbr_status_chk (
    .CORE_CLK_I, .NRST_I, .CE_I, .CMD_I, .RD_REQ_I, .MAV_I, .ALL_DONE_I, .DEV_ERR_I,
    .EXE_ERR_I, .CMD_ERR_I, .LOCAL_KEY_I, .RSP_O, .STATUS_BYTE_O, .SRQ_O
);

// >>> tb/sbr_ctl_model.sv
/* Remote controller model: sends decoded commands and collects answers.
   Assumes the block takes a command at the edge after it is driven. */
`timescale 1ns/1ns
module sbr_ctl_model
    import sbr_pkg::*;
(
    input  wire logic     clk_i,
    input  wire sbr_rsp_t rsp_i,
    output sbr_cmd_req_t  cmd_o,
    output logic          rd_req_o
);
    initial begin
        cmd_o = '0;
        rd_req_o = 1'b0;
    end
    // Idle data is inverted so nothing can lean on a stale argument
    task automatic send(input sbr_cmd_t code, input logic [7:0] data);
        @(posedge clk_i);
        cmd_o <= '{1'b1, code, data};
        @(posedge clk_i);
        cmd_o <= '{1'b0, CMD_NONE, ~data};
    endtask
    task automatic ask(input sbr_cmd_t code, output sbr_rsp_t ans);
        send(code, 8'h00);
        rd_req_o <= 1'b1;
        #1;
        ans = rsp_i;
        @(posedge clk_i);
        rd_req_o <= 1'b0;
    endtask
    task automatic bare_read();
        @(posedge clk_i);
        rd_req_o <= 1'b1;
        @(posedge clk_i);
        rd_req_o <= 1'b0;
    endtask
endmodule

// >>> tb/tb_top.sv
/* Self-checking bench for the status reporting block.
   Assumes the controller model drives commands; faults and pins come from here. */
`timescale 1ns/1ns
module tb_top;
    import sbr_pkg::*;
    logic         clk;
    logic         nrst;
    logic         mav;
    logic         done;
    logic         key;
    logic         rd;
    logic         ce;
    sbr_cmd_req_t cmd;
    sbr_err_evt_t dev_e;
    sbr_err_evt_t exe_e;
    sbr_err_evt_t cmd_e;
    sbr_rsp_t     rsp;
    logic [7:0]   sb;
    logic         srq;
    int           err_total;
    int           check_count;

    sbr_status_top u_sbr_status_top (.CORE_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .CMD_I(cmd),
        .RD_REQ_I(rd), .MAV_I(mav), .ALL_DONE_I(done), .DEV_ERR_I(dev_e), .EXE_ERR_I(exe_e),
        .CMD_ERR_I(cmd_e), .LOCAL_KEY_I(key), .RSP_O(rsp), .STATUS_BYTE_O(sb), .SRQ_O(srq));
    sbr_ctl_model u_sbr_ctl_model (.clk_i(clk), .rsp_i(rsp), .cmd_o(cmd), .rd_req_o(rd));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic close_out();
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic ask_is(input string what, input sbr_cmd_t code, input logic [15:0] exp);
        sbr_rsp_t r;
        u_sbr_ctl_model.ask(code, r);
        chk(what, {1'b1, exp}, r);
    endtask

    // Three edges cover the fault-to-byte latency plus the registered copy
    task automatic sb_is(input string what, input logic [7:0] exp);
        repeat (3) @(posedge clk);
        #1;
        chk(what, {8'h00, exp[6], exp}, {8'h00, srq, sb});
    endtask

    task automatic fault(input int sel, input logic [15:0] num);
        @(posedge clk);
        if (sel == 0)
            cmd_e <= '{1'b1, num};
        else if (sel == 1)
            exe_e <= '{1'b1, num};
        else
            dev_e <= '{1'b1, num};
        @(posedge clk);
        cmd_e.valid <= 1'b0;
        exe_e.valid <= 1'b0;
        dev_e.valid <= 1'b0;
    endtask

    task automatic t_power_on();
        ask_is("event after reset", CMD_EV_QUERY, 16'h0080);
        ask_is("event after read", CMD_EV_QUERY, 16'h0000);
        ask_is("status idle", CMD_SB_QUERY, 16'h0000);
    endtask

    task automatic t_masks();
        u_sbr_ctl_model.send(CMD_SRQMASK_SET, 8'hFF);
        ask_is("service mask", CMD_SRQMASK_QUERY, 16'h00BF);
        u_sbr_ctl_model.send(CMD_EVMASK_SET, 8'hFF);
        ask_is("event mask", CMD_EVMASK_QUERY, 16'h00FF);
    endtask

    task automatic t_faults();
        fault(0, 16'hFF6A);
        fault(1, 16'hFF06);
        fault(2, 16'hFEA2);
        fault(0, 16'hFFCE);
        sb_is("status after faults", 8'h64);
        ask_is("status query", CMD_SB_QUERY, 16'h0064);
        ask_is("fault events", CMD_EV_QUERY, 16'h0038);
        sb_is("summary cleared", 8'h44);
        ask_is("command fault", CMD_ERR_QUERY, 16'hFF6A);
        ask_is("execution fault", CMD_ERR_QUERY, 16'hFF06);
        ask_is("device fault", CMD_ERR_QUERY, 16'hFEA2);
        ask_is("out of range", CMD_ERR_QUERY, 16'hFF9C);
        ask_is("queue empty", CMD_ERR_QUERY, 16'h0000);
        sb_is("status drained", 8'h00);
    endtask

    task automatic t_mav();
        @(posedge clk);
        mav <= 1'b1;
        sb_is("message bit", 8'h50);
        @(posedge clk);
        mav <= 1'b0;
        sb_is("message gone", 8'h00);
    endtask

    task automatic t_query_err();
        sbr_rsp_t r;
        u_sbr_ctl_model.bare_read();
        ask_is("read with nothing", CMD_EV_QUERY, 16'h0004);
        u_sbr_ctl_model.send(CMD_SB_QUERY, 8'h00);
        u_sbr_ctl_model.ask(CMD_EV_QUERY, r);
        chk("answer before abandon", {1'b1, 16'h0000}, r);
        ask_is("answer abandoned", CMD_EV_QUERY, 16'h0004);
    endtask

    task automatic t_opc();
        done <= 1'b0;
        u_sbr_ctl_model.send(CMD_OPC, 8'h00);
        repeat (3) @(posedge clk);
        ask_is("still busy", CMD_EV_QUERY, 16'h0000);
        done <= 1'b1;
        repeat (2) @(posedge clk);
        ask_is("all done", CMD_EV_QUERY, 16'h0001);
    endtask

    task automatic t_local_key();
        key <= 1'b1;
        repeat (8) @(posedge clk);
        key <= 1'b0;
        ask_is("key pressed", CMD_EV_QUERY, 16'h0040);
        repeat (8) @(posedge clk);
        ask_is("key released", CMD_EV_QUERY, 16'h0000);
    endtask

    // A fault pulse while the clock enable is low must leave no trace
    task automatic t_freeze();
        ce <= 1'b0;
        fault(1, 16'hFF06);
        ce <= 1'b1;
        ask_is("frozen event", CMD_EV_QUERY, 16'h0000);
        ask_is("frozen queue", CMD_ERR_QUERY, 16'h0000);
    endtask

    task automatic t_clear();
        fault(2, 16'h0005);
        fault(2, 16'hFF00);
        fault(1, 16'hFF06);
        ask_is("positive kept", CMD_ERR_QUERY, 16'h0005);
        ask_is("device substitute", CMD_ERR_QUERY, 16'hFED4);
        u_sbr_ctl_model.send(CMD_CLEAR, 8'h00);
        ask_is("queue cleared", CMD_ERR_QUERY, 16'h0000);
        ask_is("events cleared", CMD_EV_QUERY, 16'h0000);
    endtask

    task automatic t_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        ask_is("event after second reset", CMD_EV_QUERY, 16'h0080);
        ask_is("mask after second reset", CMD_SRQMASK_QUERY, 16'h0000);
    endtask

    initial begin
        nrst = 1'b0;
        mav = 1'b0;
        done = 1'b0;
        key = 1'b0;
        ce = 1'b1;
        cmd_e = '0;
        exe_e = '0;
        dev_e = '0;
        err_total = 0;
        check_count = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_power_on();
        t_masks();
        t_faults();
        t_mav();
        t_query_err();
        t_opc();
        t_local_key();
        t_freeze();
        t_clear();
        t_reset();
        close_out();
    end

    // The sequence needs about 160 cycles
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule
